// File: design/stp_tap.sv
// Boundary-scan test access port of the SRAM: controller, instruction
// register, bypass, identification and boundary registers, serial output.
// Assumes the tester drives tck, tms and tdi; tms_open and tdi_open are
// high when the pad keeper sees the ball unconnected; rst is the system
// reset, also asserted at power-up.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Sample test inputs on rising test clock
// - Serial output changes on falling test clock
// - Mode select alone steers the controller from the third rising test clock after system reset is released
// - One register sits between data in and out
// - Five high mode samples force reset state
// - No dedicated test reset pin exists
// - System reset forces controller into reset
// - Held-low test clock keeps test logic idle
// - Floating data and mode inputs read high
// - Only a reduced instruction subset is implemented
// - Reset loads identification instruction
// - Bypass instruction shifts through one bit
module stp_tap
    import stp_pkg::*;
#(
    parameter int BSR_W = BSR_LEN                // Boundary cells
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tms_open,
    input  wire logic             tdi,
    input  wire logic             tdi_open,
    input  wire logic [BSR_W-1:0] bsr_pins,
    output logic                  tdo,
    output logic                  tdo_oe,
    output logic      [BSR_W-1:0] bsr_drive,
    output logic                  ram_out_off,
    output logic                  pins_from_scan
);

    // Refuse a boundary length that the shifter cannot serve
    if (BSR_W < 2) begin : g_bad_bsr
        $error("stp_tap: BSR_W must be at least 2");
    end

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Controller next state from the sampled mode bit
    function automatic stp_state_t tap_next(input stp_state_t s, input logic m);
        stp_state_t n;
        n = ST_TLR;
        case (s)
            ST_TLR:  n = m ? ST_TLR  : ST_RTI;
            ST_RTI:  n = m ? ST_SDR  : ST_RTI;
            ST_SDR:  n = m ? ST_SIR  : ST_CDR;
            ST_CDR:  n = m ? ST_E1DR : ST_SHDR;
            ST_SHDR: n = m ? ST_E1DR : ST_SHDR;
            ST_E1DR: n = m ? ST_UDR  : ST_PDR;
            ST_PDR:  n = m ? ST_E2DR : ST_PDR;
            ST_E2DR: n = m ? ST_UDR  : ST_SHDR;
            ST_UDR:  n = m ? ST_SDR  : ST_RTI;
            ST_SIR:  n = m ? ST_TLR  : ST_CIR;
            ST_CIR:  n = m ? ST_E1IR : ST_SHIR;
            ST_SHIR: n = m ? ST_E1IR : ST_SHIR;
            ST_E1IR: n = m ? ST_UIR  : ST_PIR;
            ST_PIR:  n = m ? ST_E2IR : ST_PIR;
            ST_E2IR: n = m ? ST_UIR  : ST_SHIR;
            ST_UIR:  n = m ? ST_SDR  : ST_RTI;
            default: n = ST_TLR;
        endcase
        return n;
    endfunction : tap_next

    // True when the instruction selects the boundary register
    function automatic logic uses_bsr(input logic [IR_W-1:0] op);
        return (op == OP_EXTEST) || (op == OP_SAMPLE_Z) || (op == OP_SAMPLE);
    endfunction : uses_bsr

    // ------------------------------------------------------------------
    // Test clock domain state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]       rst_sync;              // Release of system reset
        stp_state_t       st;                    // Controller state
        logic [IR_W-1:0]  ir;                    // Active instruction
        logic [IR_W-1:0]  ir_sh;                 // Instruction shifter
        logic             byp;                   // Bypass bit
        logic [ID_W-1:0]  id_sh;                 // Identification shifter
        logic [BSR_W-1:0] bsr_sh;                // Boundary shifter
        logic [BSR_W-1:0] bsr_upd;               // Boundary update latch
        logic             mode_hiz;              // Outputs forced off
        logic             mode_ext;              // Pins from scan cells
    } stp_tck_t;

    stp_tck_t t_r;                               // Registered state
    stp_tck_t t_nxt;                             // Next state

    logic tms_eff;                               // Mode bit after keeper
    logic tdi_eff;                               // Data bit after keeper
    logic sel_bit;                               // Last bit of selected path
    logic shifting;                              // Output driven in shift states

    // Open ball reads high so the controller drifts into reset
    assign tms_eff = tms | tms_open;
    assign tdi_eff = tdi | tdi_open;

    // ------------------------------------------------------------------
    // Path selection
    // ------------------------------------------------------------------

    // One register between tdi and tdo, by state and instruction
    always_comb begin
        if (t_r.st == ST_SHIR) begin
            sel_bit = t_r.ir_sh[0];
        end else if (uses_bsr(t_r.ir)) begin
            sel_bit = t_r.bsr_sh[0];
        end else if (t_r.ir == OP_IDCODE) begin
            sel_bit = t_r.id_sh[0];
        end else begin
            sel_bit = t_r.byp;
        end
    end

    assign shifting = (t_r.st == ST_SHIR) || (t_r.st == ST_SHDR);

    // ------------------------------------------------------------------
    // Controller and registers
    // ------------------------------------------------------------------

    // Next values from the sampled mode and data bits
    always_comb begin
        t_nxt          = t_r;
        t_nxt.rst_sync = {t_r.rst_sync[0], 1'b0};
        if (t_r.rst_sync[1]) begin
            t_nxt.st = ST_TLR;
        end else begin
            t_nxt.st = tap_next(t_r.st, tms_eff);
        end
        case (t_r.st)
            // Reset loads identification and releases the pins
            ST_TLR: begin
                t_nxt.ir       = OP_IDCODE;
                t_nxt.mode_hiz = 1'b0;
                t_nxt.mode_ext = 1'b0;
            end
            // Capture fixed pattern
            ST_CIR: begin
                t_nxt.ir_sh = IR_CAPTURE;
            end
            // Shift instruction bits toward tdo
            ST_SHIR: begin
                t_nxt.ir_sh = {tdi_eff, t_r.ir_sh[IR_W-1:1]};
            end
            // Adopt the new instruction
            ST_UIR: begin
                t_nxt.ir       = t_r.ir_sh;
                t_nxt.mode_hiz = (t_r.ir_sh == OP_SAMPLE_Z);
                t_nxt.mode_ext = (t_r.ir_sh == OP_EXTEST);
            end
            // Load selected data register
            ST_CDR: begin
                if (uses_bsr(t_r.ir)) begin
                    t_nxt.bsr_sh = bsr_pins;
                end else if (t_r.ir == OP_IDCODE) begin
                    t_nxt.id_sh = IDCODE_VAL;
                end else begin
                    t_nxt.byp = 1'b0;
                end
            end
            // Shift only the selected data register
            ST_SHDR: begin
                if (uses_bsr(t_r.ir)) begin
                    t_nxt.bsr_sh = {tdi_eff, t_r.bsr_sh[BSR_W-1:1]};
                end else if (t_r.ir == OP_IDCODE) begin
                    t_nxt.id_sh = {tdi_eff, t_r.id_sh[ID_W-1:1]};
                end else begin
                    // Reserved codes fall back to bypass
                    t_nxt.byp = tdi_eff;
                end
            end
            // Boundary cells reach the pin drivers
            ST_UDR: begin
                if (uses_bsr(t_r.ir)) begin
                    t_nxt.bsr_upd = t_r.bsr_sh;
                end
            end
            default: begin
            end
        endcase
    end

    // Rising test clock; system reset is the only asynchronous source
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            t_r          <= '0;
            t_r.rst_sync <= 2'h3;
            t_r.st       <= ST_TLR;
            t_r.ir       <= OP_IDCODE;
        end else begin
            t_r <= t_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Serial output on falling test clock
    // ------------------------------------------------------------------
    logic tdo_r;                                 // Output bit
    logic tdo_oe_r;                              // Output enable

    // Present last bit of selected path
    always_ff @(negedge tck or posedge rst) begin
        if (rst) begin
            tdo_r    <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            tdo_r    <= sel_bit;
            tdo_oe_r <= shifting;
        end
    end

    assign tdo       = tdo_r;
    assign tdo_oe    = tdo_oe_r;
    assign bsr_drive = t_r.bsr_upd;

    // ------------------------------------------------------------------
    // Mode flags into the system clock domain
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0] flags_src;                // Test-domain flops
    logic [SYNC_W-1:0] flags_m;                  // Synchronised flags

    always_comb begin
        flags_src           = '0;
        flags_src[FLAG_HIZ] = t_r.mode_hiz;
        flags_src[FLAG_EXT] = t_r.mode_ext;
    end

    stp_sync #(
        .W    (SYNC_W)
    ) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .ce   (ce),
        .d    (flags_src),
        .q    (flags_m)
    );

    typedef struct packed {
        logic off;                               // RAM outputs disabled
        logic ext;                               // Pins from scan cells
    } stp_m_t;

    stp_m_t m_r;                                 // Registered state
    stp_m_t m_nxt;                               // Next state

    // Flags hold still while tck stands low, so memory runs undisturbed
    always_comb begin
        m_nxt     = m_r;
        m_nxt.off = flags_m[FLAG_HIZ] | flags_m[FLAG_EXT];
        m_nxt.ext = flags_m[FLAG_EXT];
    end

    // System clock register, frozen while ce is low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            m_r <= '0;
        end else if (ce) begin
            m_r <= m_nxt;
        end
    end

    assign ram_out_off    = m_r.off;
    assign pins_from_scan = m_r.ext;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence seq_tms_hi5;
        tms_eff [*5];
    endsequence

    sequence seq_bypass_shift;
        (t_r.st == ST_SHDR) && (t_r.ir == OP_BYPASS);
    endsequence

    chk_reset_five: assert property (@(posedge tck) disable iff (rst)
        seq_tms_hi5 |=> (t_r.st == ST_TLR))
        else $error("five high mode samples did not reach reset");

    chk_reset_idcode: assert property (@(posedge tck) disable iff (rst)
        (t_r.st == ST_TLR) |=> (t_r.ir == OP_IDCODE))
        else $error("reset state did not load identification");

    chk_bypass_bit: assert property (@(posedge tck) disable iff (rst)
        seq_bypass_shift |=> (t_r.byp == $past(tdi_eff)))
        else $error("bypass bit did not take data input");

    chk_tdo_fall: assert property (@(negedge tck) disable iff (rst || t_r.rst_sync[1])
        tdo_r == $past(sel_bit))
        else $error("serial output not last selected bit");

    chk_id_capture: assert property (@(posedge tck) disable iff (rst)
        ((t_r.st == ST_CDR) && (t_r.ir == OP_IDCODE)) |=> (t_r.id_sh == IDCODE_VAL))
        else $error("identification value not captured");

    chk_state_onehot: assert property (@(posedge tck) disable iff (rst)
        $onehot(t_r.st))
        else $error("controller state not one-hot");

    chk_ir_update: assert property (@(posedge tck) disable iff (rst)
        (t_r.st == ST_UIR) |=> (t_r.ir == $past(t_r.ir_sh)))
        else $error("instruction not adopted on update");

    chk_mode_steer: assert property (@(posedge tck) disable iff (rst || t_r.rst_sync[1])
        ((t_r.st == ST_SDR) && tms_eff) |=> (t_r.st == ST_SIR) ##1 1'b1)
        else $error("mode select did not steer to IR scan");

    chk_open_high: assert property (@(posedge tck) disable iff (rst)
        tms_open [*5] |=> (t_r.st == ST_TLR))
        else $error("open mode ball did not settle into reset");

endmodule : stp_tap

`default_nettype wire

// File: design/stp_pkg.sv
// Constants, opcodes and state codes for the SRAM test access port.
// Assumes a single test clock domain for the scan logic and a system clock
// domain for the flags that reach the memory core.
package stp_pkg;

    // ------------------------------------------------------------------
    // Register widths
    // ------------------------------------------------------------------
    localparam int IR_W      = 3;                // Instruction register width
    localparam int ID_W      = 32;               // Identification register width
    localparam int BSR_LEN   = 109;              // Boundary scan cells

    // ------------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------------
    localparam logic [2:0] OP_EXTEST   = 3'h0;   // Drive pins from scan cells
    localparam logic [2:0] OP_IDCODE   = 3'h1;   // Select identification register
    localparam logic [2:0] OP_SAMPLE_Z = 3'h2;   // Float outputs, sample pins
    localparam logic [2:0] OP_SAMPLE   = 3'h4;   // Sample or preload pins
    localparam logic [2:0] OP_BYPASS   = 3'h7;   // One-bit path

    localparam logic [2:0] IR_CAPTURE  = 3'h1;   // Pattern captured into IR shifter
    localparam logic [31:0] IDCODE_VAL = 32'h0000_0001; // Arbitrary value, bit 0 set

    // ------------------------------------------------------------------
    // Crossing
    // ------------------------------------------------------------------
    localparam int SYNC_W     = 2;               // Mode flags crossing to mclk
    localparam int FLAG_HIZ   = 0;               // Bit: RAM outputs forced off
    localparam int FLAG_EXT   = 1;               // Bit: pins driven by scan cells

    // ------------------------------------------------------------------
    // Controller states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [15:0] {
        ST_TLR  = 16'h0001,                      // Test-logic-reset
        ST_RTI  = 16'h0002,                      // Run-test/idle
        ST_SDR  = 16'h0004,                      // Select-DR-scan
        ST_CDR  = 16'h0008,                      // Capture-DR
        ST_SHDR = 16'h0010,                      // Shift-DR
        ST_E1DR = 16'h0020,                      // Exit1-DR
        ST_PDR  = 16'h0040,                      // Pause-DR
        ST_E2DR = 16'h0080,                      // Exit2-DR
        ST_UDR  = 16'h0100,                      // Update-DR
        ST_SIR  = 16'h0200,                      // Select-IR-scan
        ST_CIR  = 16'h0400,                      // Capture-IR
        ST_SHIR = 16'h0800,                      // Shift-IR
        ST_E1IR = 16'h1000,                      // Exit1-IR
        ST_PIR  = 16'h2000,                      // Pause-IR
        ST_E2IR = 16'h4000,                      // Exit2-IR
        ST_UIR  = 16'h8000                       // Update-IR
    } stp_state_t;

endpackage : stp_pkg

// File: design/stp_sync.sv
// Three-stage level synchroniser for the mode flags entering mclk.
// Assumes the source bits come straight from flip-flops in the test domain.
`timescale 1ns/10ps
`default_nettype none

module stp_sync
    import stp_pkg::*;
#(
    parameter int W = SYNC_W                     // Number of flag bits
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // Refuse a width that the shift logic cannot serve
    if (W < 1) begin : g_bad_w
        $error("stp_sync: W must be at least 1");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] s1;                        // First stage, read by s2 only
        logic [W-1:0] s2;                        // Second stage
        logic [W-1:0] s3;                        // Third stage
        logic [W-1:0] q;                         // Accepted level
    } stp_sync_t;

    stp_sync_t r_r;                              // Registered state
    stp_sync_t r_nxt;                            // Next state

    // Shift and accept a bit once stages two and three agree
    always_comb begin
        r_nxt    = r_r;
        r_nxt.s1 = d;
        r_nxt.s2 = r_r.s1;
        r_nxt.s3 = r_r.s2;
        for (int i = 0; i < W; i++) begin
            if (r_r.s2[i] == r_r.s3[i]) begin
                r_nxt.q[i] = r_r.s3[i];
            end
        end
    end

    // Frozen while ce is low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r_r <= '0;
        end else if (ce) begin
            r_r <= r_nxt;
        end
    end

    assign q = r_r.q;

endmodule : stp_sync

`default_nettype wire

// File: test/stp_tester.sv
// Behavioural scan controller that drives the test port from outside.
// Assumes the bench calls one task at a time; tck rests low between frames.
`timescale 1ns/10ps
`default_nettype none

module stp_tester (
    output logic      tck,                       // Test clock, 64 ns period
    output logic      tms,                       // Mode select
    output logic      tdi,                       // Serial data to the port
    input  wire logic tdo,                       // Serial data from the port
    input  wire logic tdo_oe                     // Port drives tdo
);
    logic oe_seen;                               // Output enable seen at the last rise

    // ------------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------------
    initial begin
        tck = 1'b0;                              // Held low while unused
        tms = 1'b1;                              // Pull-up level
        tdi = 1'b1;                              // Pull-up level
    end

    // ------------------------------------------------------------------
    // Link steps
    // ------------------------------------------------------------------
    // One test clock period; tdo taken at the rising edge
    task automatic cyc(input logic m, input logic d, output logic q);
        tms = m;                                 // Mode select steers the port
        tdi = d;
        #32 tck = 1'b1;
        q = tdo;
        oe_seen = tdo_oe;                        // Taken with the data, away from its launch
        #32 tck = 1'b0;
    endtask : cyc

    // Five high mode samples reach reset, one low goes idle
    task automatic reset_idle();
        logic q;
        repeat (5) cyc(1'b1, 1'b1, q);
        cyc(1'b0, 1'b1, q);
    endtask : reset_idle

    // From idle into shift of the instruction or data path
    task automatic to_shift(input logic ir);
        logic q;
        cyc(1'b1, 1'b1, q);
        if (ir) begin
            cyc(1'b1, 1'b1, q);
        end
        cyc(1'b0, 1'b1, q);
        cyc(1'b0, 1'b1, q);
    endtask : to_shift

    // Shift n bits lsb first, then update and back to idle
    task automatic shift(input int n, input logic [127:0] din,
                         output logic [127:0] dout, output logic oe);
        logic q;
        dout = '0;
        oe   = 1'b1;
        for (int i = 0; i < n; i++) begin
            cyc(i == n - 1, din[i], q);
            dout[i] = q;
            oe = oe & oe_seen;
        end
        cyc(1'b1, 1'b1, q);
        cyc(1'b0, 1'b1, q);
        tdi = 1'b1;                              // Released line at pull-up
    endtask : shift
endmodule : stp_tester

`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the SRAM test access port.
// Assumes stp_tester plays the external scan controller.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import stp_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic               mclk, rst, ce, tms_open, tdi_open;
    logic               tck, tms, tdi, tdo, tdo_oe;
    logic               ram_out_off, pins_from_scan;
    logic [BSR_LEN-1:0] bsr_pins, bsr_drive;
    int                 err_total, total_checks;
    localparam logic [BSR_LEN-1:0] PIN_PAT = {1'b1, {9{12'hA5C}}};
    localparam logic [BSR_LEN-1:0] SCN_PAT = {1'b0, {9{12'h3E1}}};

    stp_tap u_stp_tap (.mclk(mclk), .rst(rst), .ce(ce), .tck(tck), .tms(tms),
        .tms_open(tms_open), .tdi(tdi), .tdi_open(tdi_open), .bsr_pins(bsr_pins),
        .tdo(tdo), .tdo_oe(tdo_oe), .bsr_drive(bsr_drive),
        .ram_out_off(ram_out_off), .pins_from_scan(pins_from_scan));

    stp_tester u_stp_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    always #20 mclk = ~mclk;                     // 25 MHz system clock

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // Load an instruction, captured pattern comes out first
    task automatic load_ir(input logic [2:0] op);
        logic [127:0] d;
        logic         oe;
        u_stp_tester.to_shift(1'b1);
        u_stp_tester.shift(3, {125'h0, op}, d, oe);
        check("ir capture", d[2:0], IR_CAPTURE);
        check("ir oe", oe, 1'b1);
    endtask : load_ir

    // Read the identification register from idle
    task automatic read_id(input int n, input logic [127:0] exp);
        logic [127:0] d;
        logic         oe;
        u_stp_tester.to_shift(1'b0);
        u_stp_tester.shift(n, '0, d, oe);
        check("id shift", d, exp);
        check("dr oe", oe, 1'b1);
    endtask : read_id

    // Bounded wait for the mode flags, sampled on the quiet edge
    task automatic wait_flags(input logic off, input logic ext);
        int n;
        n = 0;
        while ((ram_out_off !== off || pins_from_scan !== ext) && n < 20) begin
            @(negedge mclk);
            n++;
        end
        check("ram_out_off", ram_out_off, off);
        check("pins_from_scan", pins_from_scan, ext);
    endtask : wait_flags

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_bypass();
        logic [127:0] d;
        logic         oe;
        logic [2:0]   ops [4] = '{OP_BYPASS, 3'h3, 3'h5, 3'h6};
        foreach (ops[k]) begin
            load_ir(ops[k]);
            u_stp_tester.to_shift(1'b0);
            u_stp_tester.shift(8, 128'hB4, d, oe);
            check("bypass path", d[7:0], 8'h68);
        end
        $display("test bypass done");
    endtask : t_bypass

    task automatic t_float();
        logic q;
        @(posedge mclk);
        tms_open <= 1'b1;
        tdi_open <= 1'b1;
        repeat (5) u_stp_tester.cyc(1'b0, 1'b0, q);
        @(posedge mclk);
        tms_open <= 1'b0;
        u_stp_tester.cyc(1'b0, 1'b0, q);
        read_id(33, {95'h0, 1'b1, IDCODE_VAL});
        @(posedge mclk);
        tdi_open <= 1'b0;
        $display("test float done");
    endtask : t_float

    task automatic t_modes();
        logic [127:0] d;
        logic         oe;
        logic         q;
        logic [2:0]   ops [3] = '{OP_SAMPLE_Z, OP_SAMPLE, OP_EXTEST};
        logic [1:0]   fl [3] = '{2'h2, 2'h0, 2'h3};
        foreach (ops[k]) begin
            load_ir(ops[k]);
            wait_flags(fl[k][1], fl[k][0]);
        end
        u_stp_tester.to_shift(1'b0);
        u_stp_tester.shift(BSR_LEN, 128'(SCN_PAT), d, oe);
        check("bsr capture", d[BSR_LEN-1:0], PIN_PAT);
        check("bsr update", bsr_drive, SCN_PAT);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (10) @(posedge mclk);
        check("reset flags", {ram_out_off, pins_from_scan}, 2'h0);
        check("reset drive", bsr_drive, '0);
        rst <= 1'b0;
        repeat (3) u_stp_tester.cyc(1'b0, 1'b1, q);
        read_id(32, 128'(IDCODE_VAL));
        $display("test modes done");
    endtask : t_modes

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        tms_open = 1'b0;
        tdi_open = 1'b0;
        bsr_pins = PIN_PAT;
        err_total = 0;
        total_checks = 0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        u_stp_tester.reset_idle();
        read_id(32, 128'(IDCODE_VAL));
        $display("test idcode done");
        t_bypass();
        t_float();
        t_modes();
        complete_run();
    end

    initial begin
        #300000;
        err_total++;
        complete_run();
    end
endmodule : testbench

`default_nettype wire
